/* verilog/mdm_pkg.sv */
package mdm_pkg;

    // ----------------------------------------------------------------
    // clock and rates
    // ----------------------------------------------------------------
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int BASE_HZ_48 = 48000;
    localparam int BASE_HZ_44 = 44100;
    localparam int RATE_MULT_DOUBLE = 2;
    localparam int DIV_W = 9;
    // longest period rounds down to whole cycles
    localparam logic [DIV_W-1:0] FRAME_CYC_48 = DIV_W'(SYS_CLK_HZ / BASE_HZ_48);
    localparam logic [DIV_W-1:0] FRAME_CYC_44 = DIV_W'(SYS_CLK_HZ / BASE_HZ_44);
    localparam logic [DIV_W-1:0] DOUBLE_CYC_48 =
        DIV_W'(SYS_CLK_HZ / (RATE_MULT_DOUBLE * BASE_HZ_48));
    localparam logic [DIV_W-1:0] DOUBLE_CYC_44 =
        DIV_W'(SYS_CLK_HZ / (RATE_MULT_DOUBLE * BASE_HZ_44));

    // ----------------------------------------------------------------
    // widths and channel counts
    // ----------------------------------------------------------------
    localparam int SAMPLE_W = 24;
    localparam int SLOT_W = 6;
    localparam int LINK_SLOTS = 64;
    localparam int HIGH_RATE_CHANS = 32;
    localparam logic [SLOT_W-1:0] LAST_SLOT_64 = 6'h3f;
    localparam logic [SLOT_W-1:0] LAST_SLOT_32 = 6'h1f;
    localparam int MON_DELAY_FRAMES = 3;
    localparam int CFG_W = 9;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 24'h000000;

    // ----------------------------------------------------------------
    // link formats and transmit scan states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FMT_SINGLE   = 2'b00,
        FMT_SMUX     = 2'b01,
        FMT_NATIVE96 = 2'b10
    } mdm_fmt_t;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SCAN = 1'b1
    } mdm_tx_state_t;

endpackage

/* verilog/mdm_mon_if.sv */
`timescale 1ns/10ps
interface mdm_mon_if;
    import mdm_pkg::*;
    logic wr_en;
    logic [SLOT_W-1:0] wr_idx;
    logic [SAMPLE_W-1:0] wr_data;
    logic shift;
    logic [SLOT_W-1:0] rd_idx;
    logic [SAMPLE_W-1:0] rd_data;

    modport mux (
        output wr_en, wr_idx, wr_data, shift, rd_idx,
        input rd_data
    );
    modport dly (
        input wr_en, wr_idx, wr_data, shift, rd_idx,
        output rd_data
    );
endinterface

/* verilog/mdm_mon_delay.sv */
`timescale 1ns/10ps
module mdm_mon_delay
    import mdm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // monitor path
    mdm_mon_if.dly mon
);

    // ----------------------------------------------------------------
    // frame-wide delay stages
    // ----------------------------------------------------------------
    // stage 0 fills during a frame; each frame tick moves all stages on
    logic [SAMPLE_W-1:0] stage_q [MON_DELAY_FRAMES+1][LINK_SLOTS];

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int s = 0; s <= MON_DELAY_FRAMES; s++) begin
                for (int c = 0; c < LINK_SLOTS; c++) begin
                    stage_q[s][c] <= SAMPLE_RST;
                end
            end
        end else begin
            if (mon.shift) begin
                for (int s = 1; s <= MON_DELAY_FRAMES; s++) begin
                    stage_q[s] <= stage_q[s-1];
                end
            end
            if (mon.wr_en) begin
                stage_q[0][mon.wr_idx] <= mon.wr_data;
            end
        end
    end

    assign mon.rd_data = stage_q[MON_DELAY_FRAMES][mon.rd_idx];

endmodule

/* verilog/mdm_mux.sv */
`timescale 1ns/10ps
//
// Notes on behaviour
// R01 - double-rate mode runs the internal sample tick at twice the base rate (88.2 or 96 kHz).
// R02 - samples stay 24 bits wide in every mode.
// R03 - in 48K frame double rate one channel uses two adjacent link slots, recombined on receive.
// R04 - while multiplexing into the 48K frame only 32 audio channels are accepted.
// R05 - in 48K frame double rate the link frame still runs at 44.1 or 48 kHz.
// R06 - 96 kHz audio goes either multiplexed in the 48K frame or as a native 96K frame.
// R07 - double-wire AES carries one channel, odd samples in subframe A and even in subframe B.
// R08 - received audio can be sent straight back out for monitoring, bypassing the host.
// R09 - the monitor path adds a fixed delay of 3 periods from receive to transmit.
// R10 - the 48K frame carries up to 64 slots at up to 48 kHz.
// R11 - the native 96K frame carries up to 32 slots at up to 96 kHz.
// R12 - in a slot pair the lower slot holds the earlier sample and the higher the later one.
module mdm_mux
    import mdm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // configuration pins
    input wire logic rate_48k_i,
    input wire logic double_rate_mode_i,
    input wire logic frame96_i,
    input wire logic mon_enable_i,
    input wire logic [4:0] aes_chan_i,
    // host playback samples
    input wire logic play_valid_i,
    input wire logic [SLOT_W-1:0] play_chan_i,
    input wire logic [SAMPLE_W-1:0] play_data_i,
    // link receive slots
    input wire logic rx_valid_i,
    input wire logic [SLOT_W-1:0] rx_slot_i,
    input wire logic [SAMPLE_W-1:0] rx_data_i,
    // timing
    output logic sample_tick_o,
    output logic frame_tick_o,
    output logic [1:0] fmt_o,
    // link transmit slots
    output logic tx_valid_o,
    output logic tx_frame_o,
    output logic [SLOT_W-1:0] tx_slot_o,
    output logic [SAMPLE_W-1:0] tx_data_o,
    // recombined record samples
    output logic rec_valid_o,
    output logic [SLOT_W-1:0] rec_chan_o,
    output logic rec_late_o,
    output logic [SAMPLE_W-1:0] rec_data_o,
    // double-wire AES line
    output logic aes_valid_o,
    output logic [SAMPLE_W-1:0] aes_sub_a_o,
    output logic [SAMPLE_W-1:0] aes_sub_b_o
);

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    // audio channels the host may use in this format
    function automatic logic chan_ok(mdm_fmt_t f, logic [SLOT_W-1:0] ch);
        chan_ok = (f == FMT_SINGLE) || (ch < SLOT_W'(HIGH_RATE_CHANS)); // R04
    endfunction

    // link slots that carry audio in this format
    function automatic logic slot_ok(mdm_fmt_t f, logic [SLOT_W-1:0] sl);
        slot_ok = (f != FMT_NATIVE96) || (sl <= LAST_SLOT_32); // R10 R11
    endfunction

    // ----------------------------------------------------------------
    // configuration synchroniser
    // ----------------------------------------------------------------
    logic [CFG_W-1:0] cfg_meta_q;
    logic [CFG_W-1:0] cfg_q;
    mdm_fmt_t fmt_q;
    logic cfg_rate48;
    logic cfg_double;
    logic cfg_mon;
    logic [4:0] cfg_aes;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg_meta_q <= '0;
            cfg_q <= '0;
        end else begin
            cfg_meta_q <= {rate_48k_i, double_rate_mode_i, frame96_i, mon_enable_i,
                           aes_chan_i};
            cfg_q <= cfg_meta_q;
        end
    end

    assign cfg_rate48 = cfg_q[8];
    assign cfg_double = cfg_q[7];
    assign cfg_mon = cfg_q[5];
    assign cfg_aes = cfg_q[4:0];

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fmt_q <= FMT_SINGLE;
        end else if (!cfg_double) begin
            fmt_q <= FMT_SINGLE;
        end else if (cfg_q[6]) begin
            fmt_q <= FMT_NATIVE96; // R06 R11
        end else begin
            fmt_q <= FMT_SMUX; // R06
        end
    end

    // ----------------------------------------------------------------
    // sample and frame ticks
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_lim;
    logic sample_tick;
    logic frame_tick;
    logic phase_q;

    // double rate halves the period of the sample tick
    always_comb begin
        if (cfg_double) begin
            div_lim = cfg_rate48 ? DOUBLE_CYC_48 : DOUBLE_CYC_44; // R01
        end else begin
            div_lim = cfg_rate48 ? FRAME_CYC_48 : FRAME_CYC_44;
        end
    end

    // >= keeps a mode change from running the count past the limit
    assign sample_tick = (div_q >= div_lim - 1'b1);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || sample_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // phase 0 is the earlier sample of a two-sample group
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            phase_q <= 1'b0;
        end else if (sample_tick) begin
            phase_q <= cfg_double ? ~phase_q : 1'b0;
        end
    end

    // the multiplexed frame closes only every second sample
    assign frame_tick = sample_tick && ((fmt_q != FMT_SMUX) || phase_q); // R05

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sample_tick_o <= 1'b0;
            frame_tick_o <= 1'b0;
            fmt_o <= FMT_SINGLE;
        end else begin
            sample_tick_o <= sample_tick;
            frame_tick_o <= frame_tick;
            fmt_o <= fmt_q;
        end
    end

    // ----------------------------------------------------------------
    // host playback store
    // ----------------------------------------------------------------
    logic [SAMPLE_W-1:0] play_mem_q [LINK_SLOTS];
    logic [SLOT_W-1:0] play_idx;

    // in the multiplexed 48K frame a high-rate channel owns the slot pair 2c and 2c+1
    assign play_idx = (fmt_q == FMT_SMUX) ? {play_chan_i[4:0], phase_q} : play_chan_i; // R03 R12

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int c = 0; c < LINK_SLOTS; c++) begin
                play_mem_q[c] <= SAMPLE_RST;
            end
        end else if (play_valid_i && chan_ok(fmt_q, play_chan_i)) begin
            play_mem_q[play_idx] <= play_data_i; // R02
        end
    end

    // ----------------------------------------------------------------
    // transmit scan
    // ----------------------------------------------------------------
    mdm_mon_if mon ();
    mdm_tx_state_t tx_state_q;
    logic [SLOT_W-1:0] slot_q;
    logic [SLOT_W-1:0] last_slot;

    assign last_slot = (fmt_q == FMT_NATIVE96) ? LAST_SLOT_32 : LAST_SLOT_64; // R10 R11

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tx_state_q <= TX_IDLE;
            slot_q <= '0;
        end else begin
            unique case (tx_state_q)
                TX_IDLE: begin
                    if (frame_tick) begin
                        tx_state_q <= TX_SCAN;
                        slot_q <= '0;
                    end
                end
                TX_SCAN: begin
                    if (slot_q >= last_slot) begin
                        tx_state_q <= TX_IDLE;
                    end else begin
                        slot_q <= slot_q + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_frame_o <= 1'b0;
            tx_slot_o <= '0;
            tx_data_o <= SAMPLE_RST;
        end else begin
            tx_valid_o <= (tx_state_q == TX_SCAN);
            tx_frame_o <= (tx_state_q == TX_SCAN) && (slot_q == '0);
            tx_slot_o <= slot_q;
            tx_data_o <= cfg_mon ? mon.rd_data : play_mem_q[slot_q]; // R08
        end
    end

    // ----------------------------------------------------------------
    // receive recombination and monitor feed
    // ----------------------------------------------------------------
    assign mon.wr_en = rx_valid_i && slot_ok(fmt_q, rx_slot_i); // R08
    assign mon.wr_idx = rx_slot_i;
    assign mon.wr_data = rx_data_i;
    assign mon.shift = frame_tick; // R09
    assign mon.rd_idx = slot_q;

    mdm_mon_delay u_mon_delay (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .mon(mon.dly)
    );

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rec_valid_o <= 1'b0;
            rec_chan_o <= '0;
            rec_late_o <= 1'b0;
            rec_data_o <= SAMPLE_RST;
        end else begin
            rec_valid_o <= rx_valid_i && slot_ok(fmt_q, rx_slot_i);
            if (fmt_q == FMT_SMUX) begin
                rec_chan_o <= {1'b0, rx_slot_i[5:1]}; // R03
                rec_late_o <= rx_slot_i[0]; // R12
            end else begin
                rec_chan_o <= rx_slot_i;
                rec_late_o <= 1'b0;
            end
            rec_data_o <= rx_data_i;
        end
    end

    // ----------------------------------------------------------------
    // double-wire AES line
    // ----------------------------------------------------------------
    logic [SAMPLE_W-1:0] aes_a_q;
    logic [SAMPLE_W-1:0] aes_b_q;
    logic aes_hit;

    assign aes_hit = play_valid_i && cfg_double && (play_chan_i == {1'b0, cfg_aes});

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            aes_a_q <= SAMPLE_RST;
            aes_b_q <= SAMPLE_RST;
        end else if (aes_hit) begin
            if (!phase_q) begin
                aes_a_q <= play_data_i; // R07
            end else begin
                aes_b_q <= play_data_i; // R07
            end
        end
    end

    // a pair is sent once both halves of the base period are in
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            aes_valid_o <= 1'b0;
            aes_sub_a_o <= SAMPLE_RST;
            aes_sub_b_o <= SAMPLE_RST;
        end else begin
            aes_valid_o <= sample_tick && cfg_double && phase_q;
            if (sample_tick && cfg_double && phase_q) begin
                aes_sub_a_o <= aes_a_q; // R07
                aes_sub_b_o <= aes_b_q;
            end
        end
    end

endmodule

/* testbench/mdm_mux_checker.sv */
`timescale 1ns/10ps
module mdm_mux_checker
    import mdm_pkg::*;
(
    // clock, reset and pins
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic rate_48k_i,
    input wire logic rx_valid_i,
    input wire logic [SLOT_W-1:0] rx_slot_i,
    input wire logic [SAMPLE_W-1:0] rx_data_i,
    // observed outputs
    input wire logic sample_tick_o,
    input wire logic frame_tick_o,
    input wire logic [1:0] fmt_o,
    input wire logic tx_valid_o,
    input wire logic tx_frame_o,
    input wire logic [SLOT_W-1:0] tx_slot_o,
    input wire logic rec_valid_o,
    input wire logic [SLOT_W-1:0] rec_chan_o,
    input wire logic rec_late_o,
    input wire logic [SAMPLE_W-1:0] rec_data_o,
    input wire logic aes_valid_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // --------
    // link side
    // --------
    a_scan_start: assert property (frame_tick_o |=> tx_frame_o && tx_valid_o && tx_slot_o == 6'h00)
        else $error("scan did not start after frame tick");
    a_slot_step: assert property (tx_valid_o && !tx_frame_o |-> tx_slot_o == $past(tx_slot_o) + 6'h01)
        else $error("slot scan skipped a slot");
    a_native_cap: assert property (tx_valid_o && fmt_o == 2'b10 |-> tx_slot_o <= LAST_SLOT_32)
        else $error("native frame scan past slot 31");
    // rate pin stable long enough to have crossed the synchroniser
    a_smux_period: assert property (sample_tick_o && fmt_o == 2'b01 && rate_48k_i
        && $past(rate_48k_i, 4) |-> ##104 (sample_tick_o || fmt_o != 2'b01 || !rate_48k_i))
        else $error("double rate sample period wrong");
    a_frame_rate: assert property (frame_tick_o && fmt_o == 2'b01 && rate_48k_i
        && $past(rate_48k_i, 4) |-> ##104 (!frame_tick_o || fmt_o != 2'b01)
        ##104 (frame_tick_o || fmt_o != 2'b01 || !rate_48k_i))
        else $error("multiplexed frame rate wrong");
    a_rec_pair: assert property (rx_valid_i && fmt_o == 2'b01 |=> rec_valid_o
        && rec_chan_o == {1'b0, $past(rx_slot_i[5:1])} && rec_late_o == $past(rx_slot_i[0])
        && rec_data_o == $past(rx_data_i))
        else $error("slot pair not recombined");
    a_native_drop: assert property (rx_valid_i && fmt_o == 2'b10 && rx_slot_i[5] |=> !rec_valid_o)
        else $error("native frame slot above 31 accepted");
    a_aes_double: assert property (aes_valid_o |-> (fmt_o != 2'b00) ##1 (!aes_valid_o [*8]))
        else $error("double wire pair outside double rate");
endmodule

bind mdm_mux mdm_mux_checker u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rate_48k_i(rate_48k_i),
    .rx_valid_i(rx_valid_i), .rx_slot_i(rx_slot_i), .rx_data_i(rx_data_i),
    .sample_tick_o(sample_tick_o), .frame_tick_o(frame_tick_o), .fmt_o(fmt_o),
    .tx_valid_o(tx_valid_o), .tx_frame_o(tx_frame_o), .tx_slot_o(tx_slot_o),
    .rec_valid_o(rec_valid_o), .rec_chan_o(rec_chan_o), .rec_late_o(rec_late_o),
    .rec_data_o(rec_data_o), .aes_valid_o(aes_valid_o)
);

/* testbench/mdm_far_end.sv */
`timescale 1ns/10ps
module mdm_far_end
    import mdm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic frame_tick_i,
    input wire logic [7:0] tag_i,
    input wire logic tx_valid_i,
    input wire logic tx_frame_i,
    input wire logic [SLOT_W-1:0] tx_slot_i,
    input wire logic [SAMPLE_W-1:0] tx_data_i,
    output logic rx_valid_o = 1'b0,
    output logic [SLOT_W-1:0] rx_slot_o = 6'h00,
    output logic [SAMPLE_W-1:0] rx_data_o = 24'h000000
);
    logic [SAMPLE_W-1:0] seen [LINK_SLOTS];
    logic [7:0] tag_q = 8'h00;
    int scan_len = 0;
    int cnt = -1;
    // receive side keeps each slot of the last scan
    always @(posedge clk_sys_i) begin
        if (tx_valid_i) begin
            seen[tx_slot_i] <= tx_data_i;
            scan_len <= tx_frame_i ? 1 : scan_len + 1;
        end
    end
    // one full 64 slot frame per link frame tick
    always @(negedge clk_sys_i) begin
        if (cnt < 0 && frame_tick_i) begin
            cnt = 0;
            tag_q = tag_i;
        end
        if (cnt >= 0) begin
            rx_valid_o = 1'b1;
            rx_slot_o = 6'(cnt);
            rx_data_o = {tag_q, 10'h000, 6'(cnt)};
            cnt = (cnt == 63) ? -1 : cnt + 1;
        end else begin
            // released lines never hold the last value
            rx_valid_o = 1'b0;
            rx_slot_o = ~rx_slot_o;
            rx_data_o = ~rx_data_o;
        end
    end
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top
    import mdm_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic rate_48k_i = 1'b1;
    logic double_rate_mode_i = 1'b0;
    logic frame96_i = 1'b0;
    logic mon_enable_i = 1'b0;
    logic [4:0] aes_chan_i = 5'h05;
    logic play_valid_i = 1'b0;
    logic [SLOT_W-1:0] play_chan_i = 6'h00;
    logic [SAMPLE_W-1:0] play_data_i = 24'h000000;
    logic [7:0] tag = 8'h11;
    logic rx_valid_i, sample_tick_o, frame_tick_o, tx_valid_o, tx_frame_o, aes_valid_o;
    logic [SLOT_W-1:0] rx_slot_i, tx_slot_o;
    logic [1:0] fmt_o;
    logic [SAMPLE_W-1:0] rx_data_i, tx_data_o, aes_sub_a_o, aes_sub_b_o;
    int err_total = 0;
    int cmp_count = 0;

    always #50 clk_sys_i = ~clk_sys_i;

    mdm_mux dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rate_48k_i(rate_48k_i),
        .double_rate_mode_i(double_rate_mode_i), .frame96_i(frame96_i),
        .mon_enable_i(mon_enable_i), .aes_chan_i(aes_chan_i), .play_valid_i(play_valid_i),
        .play_chan_i(play_chan_i), .play_data_i(play_data_i), .rx_valid_i(rx_valid_i),
        .rx_slot_i(rx_slot_i), .rx_data_i(rx_data_i), .sample_tick_o(sample_tick_o),
        .frame_tick_o(frame_tick_o), .fmt_o(fmt_o), .tx_valid_o(tx_valid_o),
        .tx_frame_o(tx_frame_o),
        .tx_slot_o(tx_slot_o), .tx_data_o(tx_data_o), .rec_valid_o(), .rec_chan_o(),
        .rec_late_o(), .rec_data_o(), .aes_valid_o(aes_valid_o), .aes_sub_a_o(aes_sub_a_o),
        .aes_sub_b_o(aes_sub_b_o)
    );

    mdm_far_end far (
        .clk_sys_i(clk_sys_i), .frame_tick_i(frame_tick_o), .tag_i(tag),
        .tx_valid_i(tx_valid_o), .tx_frame_i(tx_frame_o), .tx_slot_i(tx_slot_o),
        .tx_data_i(tx_data_o), .rx_valid_o(rx_valid_i), .rx_slot_o(rx_slot_i),
        .rx_data_o(rx_data_i)
    );

    // --------
    // helpers
    // --------
    task automatic finish_test();
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // 0 frame tick, 1 sample tick, 2 double wire pair; n is cycles waited
    task automatic wait_ev(input int sel, output int n);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (!(sel == 0 ? frame_tick_o : sel == 1 ? sample_tick_o : aes_valid_o) && n < 500);
        if (n >= 500) chk(24'h000000, 24'h000001);
    endtask

    task automatic scan();
        int n;
        wait_ev(0, n);
        repeat (70) @(negedge clk_sys_i);
    endtask

    task automatic cfg(input logic r, d, f, m);
        int n;
        @(negedge clk_sys_i);
        rate_48k_i = r;
        double_rate_mode_i = d;
        frame96_i = f;
        mon_enable_i = m;
        wait_ev(0, n);
        wait_ev(0, n);
    endtask

    task automatic play(input logic [5:0] c, input logic [23:0] d);
        @(negedge clk_sys_i);
        play_valid_i = 1'b1;
        play_chan_i = c;
        play_data_i = d;
    endtask

    // --------
    // scenarios
    // --------
    task automatic t_single();
        cfg(1'b1, 1'b0, 1'b0, 1'b0);
        for (int c = 0; c < 64; c++) play(6'(c), {8'ha5, 10'h000, 6'(c)});
        @(negedge clk_sys_i) play_valid_i = 1'b0;
        scan();
        for (int c = 0; c < 64; c++) chk(far.seen[c], {8'ha5, 10'h000, 6'(c)});
        chk(24'(far.scan_len), 24'h000040);
    endtask

    task automatic t_smux();
        int n;
        cfg(1'b1, 1'b1, 1'b0, 1'b0);
        chk(24'(fmt_o), 24'h000001);
        wait_ev(0, n);
        for (int c = 0; c < 32; c++) play(6'(c), {8'he0, 10'h000, 6'(c)});
        @(negedge clk_sys_i) play_valid_i = 1'b0;
        wait_ev(1, n);
        for (int c = 0; c < 32; c++) play(6'(c), {8'hb0, 10'h000, 6'(c)});
        play(6'h28, 24'hdeadbe);
        @(negedge clk_sys_i) play_valid_i = 1'b0;
        wait_ev(2, n);
        chk(aes_sub_a_o, 24'he00005);
        chk(aes_sub_b_o, 24'hb00005);
        scan();
        for (int s = 0; s < 64; s++)
            chk(far.seen[s], {(s % 2 ? 8'hb0 : 8'he0), 11'h000, 5'(s / 2)});
    endtask

    task automatic t_native();
        cfg(1'b1, 1'b1, 1'b1, 1'b0);
        chk(24'(fmt_o), 24'h000002);
        for (int c = 0; c < 32; c++) play(6'(c), {8'h96, 10'h000, 6'(c)});
        @(negedge clk_sys_i) play_valid_i = 1'b0;
        scan();
        for (int c = 0; c < 32; c++) chk(far.seen[c], {8'h96, 10'h000, 6'(c)});
        chk(24'(far.scan_len), 24'h000020);
    endtask

    task automatic t_mon();
        int n;
        cfg(1'b1, 1'b0, 1'b0, 1'b1);
        @(negedge clk_sys_i) tag = 8'h5a;
        wait_ev(0, n);
        @(negedge clk_sys_i) tag = 8'h11;
        scan();
        scan();
        chk(far.seen[7], 24'h110007);
        scan();
        for (int s = 0; s < 64; s++) chk(far.seen[s], {8'h5a, 10'h000, 6'(s)});
    endtask

    task automatic t_rate();
        int n;
        cfg(1'b0, 1'b1, 1'b0, 1'b0);
        wait_ev(1, n);
        wait_ev(1, n);
        chk(24'(n), 24'(SYS_CLK_HZ / (2 * BASE_HZ_44)));
        wait_ev(0, n);
        wait_ev(0, n);
        chk(24'(n), 24'(SYS_CLK_HZ / BASE_HZ_44));
    endtask

    initial begin
        repeat (20) @(negedge clk_sys_i);
        rst_i = 1'b0;
        t_single();
        t_smux();
        t_native();
        t_mon();
        t_rate();
        finish_test();
    end

    // whole run needs well under 10000 cycles
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        err_total++;
        finish_test();
    end
endmodule
